// ### design/bstp_pkg.sv
// Purpose: shared constants and types of the boundary-scan test port
// Assumes: tester pins arrive asynchronously and are sampled by clk_i
// Notes: Function list below
// Function
// - three-bit instruction chain, shifted LSB first
// - only test clock edges move scan data
// - decoded instruction picks test and chain
// - code 000 puts pin chain in path
// - external test captures pins, then shifts out
// - external test drives pins after update
// - code 100 selects and captures pin chain
// - sample/preload keeps normal core-to-pin path
// - code 110 selects identification chain
// - identification word shifts out in shift-data
// - code 111 gives one-period pass path
// - 32-bit identification, bit0 one, LSB first
// - pass path is a single stage
// - pin chain is 98 bits long
// - five mode-select highs force test reset
package bstp_pkg;

  // ----------------------------------------------------------------
  // widths and codes
  // ----------------------------------------------------------------
  localparam int unsigned BSTP_IR_LEN = 3;
  localparam int unsigned BSTP_ID_LEN = 32;
  localparam int unsigned BSTP_PIN_LEN = 98;
  localparam int unsigned BSTP_SYNC_STAGES = 2;

  typedef logic [BSTP_IR_LEN-1:0] bstp_instr_t;

  localparam bstp_instr_t BSTP_INSTR_EXTEST = 3'h0;
  localparam bstp_instr_t BSTP_INSTR_SAMPLE = 3'h4;
  localparam bstp_instr_t BSTP_INSTR_IDCODE = 3'h6;
  localparam bstp_instr_t BSTP_INSTR_BYPASS = 3'h7;
  // fixed pattern loaded into the instruction chain on capture
  localparam bstp_instr_t BSTP_IR_CAPTURE = 3'h1;

  // identification word; the value is arbitrary, bit 0 must stay one
  localparam logic [BSTP_ID_LEN-1:0] BSTP_ID_DEFAULT = 32'h0A5C_3001;
  localparam int unsigned BSTP_ID_FIXED_BIT = 0;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BSTP_TLR,
    BSTP_IDLE,
    BSTP_SEL_DR,
    BSTP_CAP_DR,
    BSTP_SHIFT_DR,
    BSTP_EXIT1_DR,
    BSTP_PAUSE_DR,
    BSTP_EXIT2_DR,
    BSTP_UPD_DR,
    BSTP_SEL_IR,
    BSTP_CAP_IR,
    BSTP_SHIFT_IR,
    BSTP_EXIT1_IR,
    BSTP_PAUSE_IR,
    BSTP_EXIT2_IR,
    BSTP_UPD_IR
  } bstp_state_e;

  // tester-side inputs travel together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstp_scan_in_s;

endpackage : bstp_pkg

// ### design/bstp_sync.sv
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: one clock, synchronous active-high reset
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module bstp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import bstp_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("bstp_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : bstp_sync
`default_nettype wire

// ### design/bstp_top.sv
// Purpose: boundary-scan test access port with pin chain, id and pass path
// Assumes: test clock far slower than clk_i (at least 4 clk_i per phase)
// Notes: tdo changes on falling test-clock edges, as testers expect
`timescale 1ns/1ps
`default_nettype none
module bstp_top #(
  parameter int unsigned PIN_LEN = bstp_pkg::BSTP_PIN_LEN,
  parameter logic [bstp_pkg::BSTP_ID_LEN-1:0] ID_VALUE = bstp_pkg::BSTP_ID_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bstp_pkg::bstp_scan_in_s scan_i,
  input wire logic [PIN_LEN-1:0] pin_level_i,
  input wire logic [PIN_LEN-1:0] core_drive_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [PIN_LEN-1:0] pin_drive_o,
  output logic extest_o,
  output logic test_reset_o
);
  import bstp_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (PIN_LEN < 2) begin : g_bad_len
    $error("bstp_top: PIN_LEN must be at least 2");
  end
  if (ID_VALUE[BSTP_ID_FIXED_BIT] != 1'b1) begin : g_bad_id
    $error("bstp_top: identification bit 0 must be one");
  end

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  bstp_scan_in_s scan_s;
  logic [PIN_LEN-1:0] pin_level_s;

  bstp_sync #(
    .WIDTH($bits(bstp_scan_in_s))
  ) u_sync_scan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(scan_i),
    .sync_o(scan_s)
  );

  // pin levels are sampled like any other asynchronous input
  bstp_sync #(
    .WIDTH(PIN_LEN)
  ) u_sync_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pin_level_i),
    .sync_o(pin_level_s)
  );

  // ----------------------------------------------------------------
  // test clock edge detection
  // ----------------------------------------------------------------
  logic tck_prev_q;
  wire tck_rise = scan_s.tck & ~tck_prev_q;
  wire tck_fall = ~scan_s.tck & tck_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= scan_s.tck;
    end
  end

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  bstp_state_e state_q;
  bstp_state_e state_d;
  wire tms = scan_s.tms;

  always_comb begin
    state_d = state_q;
    case (state_q)
      BSTP_TLR: begin
        state_d = tms ? BSTP_TLR : BSTP_IDLE;
      end
      BSTP_IDLE: begin
        state_d = tms ? BSTP_SEL_DR : BSTP_IDLE;
      end
      BSTP_SEL_DR: begin
        state_d = tms ? BSTP_SEL_IR : BSTP_CAP_DR;
      end
      BSTP_CAP_DR: begin
        state_d = tms ? BSTP_EXIT1_DR : BSTP_SHIFT_DR;
      end
      BSTP_SHIFT_DR: begin
        state_d = tms ? BSTP_EXIT1_DR : BSTP_SHIFT_DR;
      end
      BSTP_EXIT1_DR: begin
        state_d = tms ? BSTP_UPD_DR : BSTP_PAUSE_DR;
      end
      BSTP_PAUSE_DR: begin
        state_d = tms ? BSTP_EXIT2_DR : BSTP_PAUSE_DR;
      end
      BSTP_EXIT2_DR: begin
        state_d = tms ? BSTP_UPD_DR : BSTP_SHIFT_DR;
      end
      BSTP_UPD_DR: begin
        state_d = tms ? BSTP_SEL_DR : BSTP_IDLE;
      end
      // sel-ir with high falls to reset
      BSTP_SEL_IR: begin
        state_d = tms ? BSTP_TLR : BSTP_CAP_IR;
      end
      BSTP_CAP_IR: begin
        state_d = tms ? BSTP_EXIT1_IR : BSTP_SHIFT_IR;
      end
      BSTP_SHIFT_IR: begin
        state_d = tms ? BSTP_EXIT1_IR : BSTP_SHIFT_IR;
      end
      BSTP_EXIT1_IR: begin
        state_d = tms ? BSTP_UPD_IR : BSTP_PAUSE_IR;
      end
      BSTP_PAUSE_IR: begin
        state_d = tms ? BSTP_EXIT2_IR : BSTP_PAUSE_IR;
      end
      BSTP_EXIT2_IR: begin
        state_d = tms ? BSTP_UPD_IR : BSTP_SHIFT_IR;
      end
      BSTP_UPD_IR: begin
        state_d = tms ? BSTP_SEL_DR : BSTP_IDLE;
      end
      default: begin
        state_d = BSTP_TLR;
      end
    endcase
  end

  // state moves on test clock rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BSTP_TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  wire in_tlr = (state_q == BSTP_TLR);
  wire in_cap_dr = (state_q == BSTP_CAP_DR);
  wire in_shift_dr = (state_q == BSTP_SHIFT_DR);
  wire in_upd_dr = (state_q == BSTP_UPD_DR);
  wire in_cap_ir = (state_q == BSTP_CAP_IR);
  wire in_shift_ir = (state_q == BSTP_SHIFT_IR);
  wire in_upd_ir = (state_q == BSTP_UPD_IR);

  // ----------------------------------------------------------------
  // instruction chain and decode
  // ----------------------------------------------------------------
  bstp_instr_t ir_shift_q;
  bstp_instr_t instr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_shift_q <= BSTP_IR_CAPTURE;
    end else if (tck_rise && in_cap_ir) begin
      ir_shift_q <= BSTP_IR_CAPTURE;
    end else if (tck_rise && in_shift_ir) begin
      ir_shift_q <= {scan_s.tdi, ir_shift_q[BSTP_IR_LEN-1:1]};
    end
  end

  // test reset loads identification
  // loaded on the rise that enters test reset, so no stale extest lingers there
  wire to_tlr = tck_rise & (state_d == BSTP_TLR);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_q <= BSTP_INSTR_IDCODE;
    end else if (to_tlr) begin
      instr_q <= BSTP_INSTR_IDCODE;
    end else if (tck_rise && in_upd_ir) begin
      instr_q <= ir_shift_q;
    end
  end

  wire sel_extest = (instr_q == BSTP_INSTR_EXTEST);
  wire sel_sample = (instr_q == BSTP_INSTR_SAMPLE);
  wire sel_id = (instr_q == BSTP_INSTR_IDCODE);
  wire sel_pin = sel_extest | sel_sample;
  wire sel_bypass = ~sel_pin & ~sel_id;

  // ----------------------------------------------------------------
  // pin boundary chain
  // ----------------------------------------------------------------
  logic [PIN_LEN-1:0] pin_chain_q;
  logic [PIN_LEN-1:0] pin_update_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_chain_q <= '0;
    end else if (tck_rise && in_cap_dr && sel_pin) begin
      pin_chain_q <= pin_level_s;
    end else if (tck_rise && in_shift_dr && sel_pin) begin
      pin_chain_q <= {scan_s.tdi, pin_chain_q[PIN_LEN-1:1]};
    end
  end

  // preload also lands here so extest starts from a known pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_update_q <= '0;
    end else if (tck_rise && in_upd_dr && sel_pin) begin
      pin_update_q <= pin_chain_q;
    end
  end

  // ----------------------------------------------------------------
  // identification chain and pass path
  // ----------------------------------------------------------------
  logic [BSTP_ID_LEN-1:0] id_chain_q;
  logic bypass_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      id_chain_q <= ID_VALUE;
    end else if (tck_rise && in_cap_dr && sel_id) begin
      id_chain_q <= ID_VALUE;
    end else if (tck_rise && in_shift_dr && sel_id) begin
      id_chain_q <= {scan_s.tdi, id_chain_q[BSTP_ID_LEN-1:1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bypass_q <= 1'b0;
    end else if (tck_rise && in_cap_dr && sel_bypass) begin
      bypass_q <= 1'b0;
    end else if (tck_rise && in_shift_dr && sel_bypass) begin
      bypass_q <= scan_s.tdi;
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  wire dr_bit = sel_pin ? pin_chain_q[0] : (sel_id ? id_chain_q[0] : bypass_q);
  wire shifting = in_shift_dr | in_shift_ir;
  wire out_bit = in_shift_ir ? ir_shift_q[0] : dr_bit;

  // falling-edge launch gives the tester half a period of setup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= shifting ? out_bit : 1'b0;
      tdo_oe_o <= shifting;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // extest drives pins from update
  wire [PIN_LEN-1:0] pin_drive_d = sel_extest ? pin_update_q : core_drive_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_drive_o <= '0;
      extest_o <= 1'b0;
      test_reset_o <= 1'b1;
    end else begin
      pin_drive_o <= pin_drive_d;
      extest_o <= sel_extest;
      test_reset_o <= in_tlr;
    end
  end

endmodule : bstp_top
`default_nettype wire

// ### tb/bstp_tester.sv
// Purpose: tester model that drives the scan pins one bit at a time
// Assumes: test clock period of 80 ns, ten clk_i cycles per bit
// Notes: tck rests low between bits; tdo is taken just before each rise
`timescale 1ns/1ps
`default_nettype none
module bstp_tester (
  input wire logic clk_i,
  input wire logic tdo_i,
  output var bstp_pkg::bstp_scan_in_s scan_o
);
  import bstp_pkg::*;
  initial scan_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
  // one tck period, tms and tdi steady around the rise
  task automatic bit_step(input logic tms, input logic tdi, output logic tdo);
    @(negedge clk_i);
    scan_o.tms = tms;
    scan_o.tdi = tdi;
    repeat (4) @(negedge clk_i);
    tdo = tdo_i;
    scan_o.tck = 1'b1;
    repeat (5) @(negedge clk_i);
    scan_o.tck = 1'b0;
  endtask : bit_step
endmodule : bstp_tester
`default_nettype wire

// ### tb/bstp_top_sva.sv
// Purpose: port-level checks of the scan port
// Assumes: tck edges are seen one clk_i after they reach the pin
// Notes: bounds leave room for the two-flop input synchroniser
`timescale 1ns/1ps
`default_nettype none
module bstp_top_sva #(
  parameter int unsigned PIN_LEN = 98
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bstp_pkg::bstp_scan_in_s scan_i,
  input wire logic [PIN_LEN-1:0] pin_level_i,
  input wire logic [PIN_LEN-1:0] core_drive_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [PIN_LEN-1:0] pin_drive_o,
  input wire logic extest_o,
  input wire logic test_reset_o
);
  import bstp_pkg::*;
  // ----------------------------------------------------------------
  // tck edge tracking
  // ----------------------------------------------------------------
  logic tck_q;
  logic [3:0] since_rise_q;
  logic [3:0] since_fall_q;
  logic [2:0] ones_q;
  wire logic tck_rise;
  wire logic tck_fall;
  assign tck_rise = scan_i.tck & ~tck_q;
  assign tck_fall = ~scan_i.tck & tck_q;
  always_ff @(posedge clk_i) begin
    tck_q <= scan_i.tck;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) since_rise_q <= 4'hF;
    else if (tck_rise) since_rise_q <= 4'h0;
    else if (since_rise_q != 4'hF) since_rise_q <= since_rise_q + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) since_fall_q <= 4'hF;
    else if (tck_fall) since_fall_q <= 4'h0;
    else if (since_fall_q != 4'hF) since_fall_q <= since_fall_q + 4'h1;
  end
  // saturating run of rises with mode select high
  always_ff @(posedge clk_i) begin
    if (rst_i) ones_q <= 3'h0;
    else if (tck_rise && !scan_i.tms) ones_q <= 3'h0;
    else if (tck_rise && ones_q != 3'h7) ones_q <= ones_q + 3'h1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RESET_STATE: assert property (
    $fell(rst_i) |-> test_reset_o && !extest_o && !tdo_oe_o && !tdo_o)
    else $error("outputs not at reset values");
  AST_TDO_QUIET: assert property (!tdo_oe_o |-> !tdo_o)
    else $error("tdo high while not driving");
  AST_TDO_ON_FALL: assert property (
    !$stable(tdo_o) || !$stable(tdo_oe_o) |-> since_fall_q <= 4'h6)
    else $error("tdo moved away from a falling tck");
  AST_OE_RISE_HOLD: assert property ($rose(tdo_oe_o) |=> tdo_oe_o[*4])
    else $error("tdo enable dropped early");
  AST_OE_FALL_HOLD: assert property ($fell(tdo_oe_o) |=> !tdo_oe_o[*4])
    else $error("tdo enable rose early");
  AST_PIN_NORMAL: assert property (
    !extest_o[*4] |-> pin_drive_o == $past(core_drive_i))
    else $error("pins not following core outside extest");
  AST_EXTEST_HOLD: assert property (
    extest_o[*3] ##1 (extest_o && !$stable(pin_drive_o)) |-> since_rise_q <= 4'h8)
    else $error("pins changed without an update");
  AST_TMS_RESET: assert property ($rose(ones_q == 3'h5) |-> ##[1:6] test_reset_o)
    else $error("five mode-select highs gave no test reset");
  AST_TLR_NOT_EXTEST: assert property (test_reset_o[*4] |-> !extest_o)
    else $error("extest active in test reset");
  COV_EXTEST: cover property ($rose(extest_o));
  COV_SHIFT: cover property ($rose(tdo_oe_o));
  COV_TMS_RESET: cover property ($rose(ones_q == 3'h5));
endmodule : bstp_top_sva
bind bstp_top bstp_top_sva #(.PIN_LEN(PIN_LEN)) bstp_top_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .scan_i(scan_i), .pin_level_i(pin_level_i),
  .core_drive_i(core_drive_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .pin_drive_o(pin_drive_o), .extest_o(extest_o), .test_reset_o(test_reset_o));
`default_nettype wire

// ### tb/bstp_top_tb.sv
// Purpose: self-checking bench of the scan port against a queue model
// Assumes: tester model moves one bit per ten clk_i cycles
// Notes: every code is loaded and scanned past its chain length
`timescale 1ns/1ps
`default_nettype none
module bstp_top_tb;
  import bstp_pkg::*;
  localparam int unsigned PL = BSTP_PIN_LEN;
  // arbitrary identification value, bit 0 kept at one
  localparam logic [31:0] TB_ID = 32'h1234_5679;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  bstp_scan_in_s scan;
  logic [PL-1:0] pins = '0;
  logic [PL-1:0] core = '0;
  logic [PL-1:0] upd = '0;
  logic [PL-1:0] pin_drive;
  logic tdo, tdo_oe, extest, test_reset, last_tdo;
  logic [31:0] seed = 32'h232C;
  bstp_instr_t cur_ir;
  int n_errors = 0;
  int compares = 0;

  always #4 clk_i = ~clk_i;

  bstp_top #(.PIN_LEN(PL), .ID_VALUE(TB_ID)) bstp_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .scan_i(scan), .pin_level_i(pins),
    .core_drive_i(core), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_drive_o(pin_drive),
    .extest_o(extest), .test_reset_o(test_reset));
  bstp_tester bstp_tester_i (.clk_i(clk_i), .tdo_i(tdo), .scan_o(scan));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic rnd(output logic [PL-1:0] v);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = {v[PL-33:0], seed};
    end
  endtask : rnd
  task automatic chk(input logic [PL-1:0] got, input logic [PL-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input logic tms, input logic tdi);
    bstp_tester_i.bit_step(tms, tdi, last_tdo);
  endtask : step
  task automatic give_verdict();
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // from idle: select, capture, shift three bits, update
  task automatic load_ir(input bstp_instr_t code);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i]);
      chk(last_tdo, BSTP_IR_CAPTURE[i]);
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    cur_ir = code;
  endtask : load_ir

  // capture, shift n random bits, update; the queue is the selected chain
  task automatic dr_scan(input int n);
    logic q[$];
    logic tdi;
    rnd(pins);
    rnd(core);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    case (cur_ir)
      BSTP_INSTR_EXTEST, BSTP_INSTR_SAMPLE: for (int k = 0; k < PL; k++) q.push_back(pins[k]);
      BSTP_INSTR_IDCODE: for (int k = 0; k < 32; k++) q.push_back(TB_ID[k]);
      default: q.push_back(1'b0);
    endcase
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      tdi = seed[0];
      q.push_back(tdi);
      step(i == n - 1, tdi);
      chk(last_tdo, q.pop_front());
      chk(tdo_oe, 1'b1);
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    if (cur_ir == BSTP_INSTR_EXTEST || cur_ir == BSTP_INSTR_SAMPLE) begin
      for (int k = 0; k < PL; k++) upd[k] = q[k];
    end
    chk(tdo_oe, 1'b0);
    chk(extest, cur_ir == BSTP_INSTR_EXTEST);
    chk(pin_drive, (cur_ir == BSTP_INSTR_EXTEST) ? upd : core);
    chk(test_reset, 1'b0);
  endtask : dr_scan

  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(test_reset, 1'b1);
    chk(extest, 1'b0);
    step(1'b0, 1'b0);
    cur_ir = BSTP_INSTR_IDCODE;
    dr_scan(40);
    for (int c = 0; c < 8; c++) begin
      load_ir(bstp_instr_t'(c));
      dr_scan(PL + 8);
    end
    // preload from sample must reach the pins once extest is loaded
    load_ir(BSTP_INSTR_EXTEST);
    chk(pin_drive, upd);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    repeat (5) step(1'b1, 1'b1);
    repeat (4) @(negedge clk_i);
    chk(test_reset, 1'b1);
    chk(extest, 1'b0);
    chk(pin_drive, core);
    step(1'b0, 1'b0);
    cur_ir = BSTP_INSTR_IDCODE;
    dr_scan(33);
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
endmodule : bstp_top_tb
`default_nettype wire
